// ---- adc_dio_pkg.sv ----
// constants for the converter status and port direction block
package adc_dio_pkg;
  // ******************************
  // port addresses
  // ******************************
  localparam logic [15:0] ADDR_INDUSTRIAL_IO_CONTROL = 16'h01D3;
  localparam logic [15:0] ADDR_LOWER_PORT_DATA = 16'h01D4;
  localparam logic [15:0] ADDR_UPPER_PORT_DATA = 16'h01D5;
  localparam logic [15:0] ADDR_ADC_RESULT_LOW = 16'h01D8;
  localparam logic [15:0] ADDR_ADC_RESULT_HIGH = 16'h01D9;
  localparam logic [15:0] ADDR_ANALOG_CHANNEL_CONTROL = 16'h01D8;
  // ******************************
  // field positions and widths
  // ******************************
  localparam int DONE_BIT = 7;
  localparam int UPPER_DIR_BIT = 1;
  localparam int LOWER_DIR_BIT = 0;
  localparam int RESULT_W = 12;
  localparam int CHANNEL_W = 3;
  localparam int PORT_W = 8;
  localparam int SYNC_STAGES = 3;
  // ******************************
  // reset values
  // ******************************
  localparam logic RST_DIR = 1'b0;
  localparam logic RST_DONE = 1'b0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_RESULT = 12'h000;
  localparam logic [2:0] RST_CHANNEL = 3'h0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ******************************
  // conversion sequencer states
  // ******************************
  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_BUSY = 2'b01
  } conv_state_t;
endpackage

// ---- adc_status_and_dio_direction.sv ----
// register logic for the analog converter status and digital port direction
`timescale 1ns/10ps
// Operation
// - status register bit 7 reads 0 while converting, 1 when result is valid
// - starting a new conversion forces the done bit to 0
// - reading either result register or writing channel control clears done
// - control bits 6..2 and high result bits 7..4 do nothing, writes ignored
// - control bit 1 sets upper port lines 15..8 direction, 1 is output
// - control bit 0 sets lower port lines 7..0 direction, 1 is output
// - high result register returns result bits 11..8 in bits 3..0
// - low result register returns result bits 7..0
// - result is a 12-bit unsigned code of 4096 steps
// - code zero means grounded input, one step per millivolt, truncated
// - all codes positive, 0FFF is full scale
// - word read at low result address returns low then high as one access
// - writing a channel number to channel control starts conversion there
// - channel control bits 2..0 select one of eight inputs, others ignored
// - output port drives data register, input port reads line states
// - both port directions reset to input
// - completion may raise an interrupt request when so configured
module adc_status_and_dio_direction (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic io_word_i,
  input wire logic [7:0] io_wdata_i,
  output logic [15:0] io_rdata_o,
  output logic conv_start_o,
  output logic [2:0] channel_select_o,
  input wire logic conv_done_i,
  input wire logic [11:0] conv_result_i,
  input wire logic irq_enable_i,
  output logic adc_irq_o,
  input wire logic [15:0] port_line_i,
  output logic [15:0] port_line_o,
  output logic [15:0] port_line_oe_o
);
  // ******************************
  // state
  // ******************************
  adc_dio_pkg::conv_state_t state_r, state_nxt;
  logic done_r, done_nxt;
  logic upper_port_direction_r, upper_port_direction_nxt;
  logic lower_port_direction_r, lower_port_direction_nxt;
  logic [7:0] upper_data_r, upper_data_nxt;
  logic [7:0] lower_data_r, lower_data_nxt;
  logic [11:0] result_r, result_nxt;
  logic [2:0] channel_r, channel_nxt;
  logic start_r, start_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [15:0] sync1_r, sync2_r, sync3_r;
  logic [15:0] line_state_r, line_state_nxt;
  logic chan_wr, result_rd;

  // ******************************
  // read decode
  // ******************************
  // byte seen by a read at one address; unmapped ports read as zero
  function automatic logic [7:0] read_byte(input logic [15:0] a, input logic dn,
                                           input logic ud, input logic ld,
                                           input logic [11:0] res,
                                           input logic [15:0] lines,
                                           input logic [7:0] ureg,
                                           input logic [7:0] lreg);
    logic [7:0] b;
    b = adc_dio_pkg::RST_BYTE;
    unique case (a)
      adc_dio_pkg::ADDR_INDUSTRIAL_IO_CONTROL: begin
        // bits 6..2 are not stored, so they always read back as zero
        b[adc_dio_pkg::DONE_BIT] = dn;
        b[adc_dio_pkg::UPPER_DIR_BIT] = ud;
        b[adc_dio_pkg::LOWER_DIR_BIT] = ld;
      end
      adc_dio_pkg::ADDR_LOWER_PORT_DATA: b = ld ? lreg : lines[7:0];
      adc_dio_pkg::ADDR_UPPER_PORT_DATA: b = ud ? ureg : lines[15:8];
      adc_dio_pkg::ADDR_ADC_RESULT_LOW: b = res[7:0];
      adc_dio_pkg::ADDR_ADC_RESULT_HIGH: b = {4'h0, res[11:8]};
      default: b = adc_dio_pkg::RST_BYTE;
    endcase
    return b;
  endfunction

  // ******************************
  // host access and conversion
  // ******************************
  always_comb begin
    state_nxt = state_r;
    done_nxt = done_r;
    upper_port_direction_nxt = upper_port_direction_r;
    lower_port_direction_nxt = lower_port_direction_r;
    upper_data_nxt = upper_data_r;
    lower_data_nxt = lower_data_r;
    result_nxt = result_r;
    channel_nxt = channel_r;
    start_nxt = 1'b0;
    rdata_nxt = rdata_r;
    chan_wr = io_wr_i && (io_addr_i == adc_dio_pkg::ADDR_ANALOG_CHANNEL_CONTROL);
    // a word read at the low address also covers the high register, and one
    // just below it reaches the low register, so both clear done as well
    result_rd = io_rd_i && ((io_addr_i == adc_dio_pkg::ADDR_ADC_RESULT_LOW) ||
                (io_addr_i == adc_dio_pkg::ADDR_ADC_RESULT_HIGH) ||
                (io_word_i && (io_addr_i == adc_dio_pkg::ADDR_ADC_RESULT_LOW - 16'h0001)));
    // read data is registered and stands until the next read
    if (io_rd_i) begin
      rdata_nxt[7:0] = read_byte(io_addr_i, done_r, upper_port_direction_r,
                                 lower_port_direction_r, result_r, line_state_r,
                                 upper_data_r, lower_data_r);
      // a byte read leaves the high byte at zero
      rdata_nxt[15:8] = io_word_i ? read_byte(16'(io_addr_i + 16'h0001), done_r,
                                 upper_port_direction_r, lower_port_direction_r,
                                 result_r, line_state_r, upper_data_r,
                                 lower_data_r) : adc_dio_pkg::RST_BYTE;
    end
    if (result_rd) begin
      done_nxt = 1'b0;
    end
    if (io_wr_i) begin
      unique case (io_addr_i)
        adc_dio_pkg::ADDR_INDUSTRIAL_IO_CONTROL: begin
          upper_port_direction_nxt = io_wdata_i[adc_dio_pkg::UPPER_DIR_BIT];
          lower_port_direction_nxt = io_wdata_i[adc_dio_pkg::LOWER_DIR_BIT];
        end
        adc_dio_pkg::ADDR_LOWER_PORT_DATA: lower_data_nxt = io_wdata_i;
        adc_dio_pkg::ADDR_UPPER_PORT_DATA: upper_data_nxt = io_wdata_i;
        // the high result register and unmapped ports ignore writes
        default: ;
      endcase
    end
    unique case (state_r)
      // idle until the next channel write
      adc_dio_pkg::CONV_IDLE: ;
      adc_dio_pkg::CONV_BUSY: begin
        if (conv_done_i && !chan_wr) begin
          // both halves change together so a low/high pair never tears
          result_nxt = conv_result_i;
          // a result read in this cycle cleared done above; the set wins
          done_nxt = 1'b1;
          state_nxt = adc_dio_pkg::CONV_IDLE;
        end
      end
      default: state_nxt = adc_dio_pkg::CONV_IDLE;
    endcase
    // a restart outranks a completion landing in the same cycle
    if (chan_wr) begin
      // channel bits above the select are dropped
      channel_nxt = io_wdata_i[adc_dio_pkg::CHANNEL_W-1:0];
      start_nxt = 1'b1;
      done_nxt = 1'b0;
      state_nxt = adc_dio_pkg::CONV_BUSY;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= adc_dio_pkg::CONV_IDLE;
      done_r <= adc_dio_pkg::RST_DONE;
      upper_port_direction_r <= adc_dio_pkg::RST_DIR;
      lower_port_direction_r <= adc_dio_pkg::RST_DIR;
      upper_data_r <= adc_dio_pkg::RST_BYTE;
      lower_data_r <= adc_dio_pkg::RST_BYTE;
      result_r <= adc_dio_pkg::RST_RESULT;
      channel_r <= adc_dio_pkg::RST_CHANNEL;
      start_r <= 1'b0;
      rdata_r <= adc_dio_pkg::RST_WORD;
    end else begin
      state_r <= state_nxt;
      done_r <= done_nxt;
      upper_port_direction_r <= upper_port_direction_nxt;
      lower_port_direction_r <= lower_port_direction_nxt;
      upper_data_r <= upper_data_nxt;
      lower_data_r <= lower_data_nxt;
      result_r <= result_nxt;
      channel_r <= channel_nxt;
      start_r <= start_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ******************************
  // port line input synchroniser
  // ******************************
  // only accept a line change once the last two stages agree
  // pin reads lag the pins by about four cycles, fine for slow lines
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      line_state_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : line_state_r[i];
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sync1_r <= adc_dio_pkg::RST_WORD;
      sync2_r <= adc_dio_pkg::RST_WORD;
      sync3_r <= adc_dio_pkg::RST_WORD;
      line_state_r <= adc_dio_pkg::RST_WORD;
    end else begin
      sync1_r <= port_line_i;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      line_state_r <= line_state_nxt;
    end
  end

  // ******************************
  // outputs
  // ******************************
  assign io_rdata_o = rdata_r;
  assign conv_start_o = start_r;
  assign channel_select_o = channel_r;
  // a level, not a pulse: it stays up until the host clears done
  assign adc_irq_o = done_r & irq_enable_i;
  assign port_line_o = {upper_data_r, lower_data_r};
  // reset drops both enables, so the lines float to their pull-ups
  assign port_line_oe_o = {{8{upper_port_direction_r}},
                           {8{lower_port_direction_r}}};
endmodule

// ---- conv_model.sv ----
// converter model: one done pulse a short or a long wait after the latest start; a new start reloads the wait
`timescale 1ns/10ps
module conv_model (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic slow_i,
  input wire logic [11:0] code_i,
  output logic done_o,
  output logic [11:0] result_o
);
  logic [3:0] cnt_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) cnt_r <= 4'h0;
    else if (start_i) cnt_r <= slow_i ? 4'hC : 4'h3;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign done_o = cnt_r == 4'h1;
  // code is only valid with the pulse; inverted otherwise so a stale value never matches
  assign result_o = done_o ? code_i : ~code_i;
endmodule

// ---- adc_status_and_dio_direction_chk.sv ----
// assertions on the converter status and port direction block
`timescale 1ns/10ps
module adc_status_and_dio_direction_chk (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [15:0] io_rdata_o,
  input wire logic conv_start_o,
  input wire logic [2:0] channel_select_o,
  input wire logic conv_done_i,
  input wire logic irq_enable_i,
  input wire logic adc_irq_o,
  input wire logic [15:0] port_line_oe_o
);
  logic ch_wr, dir_wr, res_rd;
  assign ch_wr = io_wr_i && io_addr_i == 16'h01D8;
  assign dir_wr = io_wr_i && io_addr_i == 16'h01D3;
  assign res_rd = io_rd_i && io_addr_i[15:1] == 15'h00EC;
  // follows the block's conversion state from the outside
  logic busy_r;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= ch_wr || (busy_r && !conv_done_i);
    end
  end
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);
  chan_go_a: assert property (ch_wr |=> conv_start_o &&
    channel_select_o == $past(io_wdata_i[2:0])) else $error("bad start");
  no_go_a: assert property (!ch_wr |=> !conv_start_o)
    else $error("stray start");
  dir_set_a: assert property (dir_wr |=> port_line_oe_o ==
    {{8{$past(io_wdata_i[1])}}, {8{$past(io_wdata_i[0])}}}) else $error("bad oe");
  dir_keep_a: assert property (!dir_wr |=> $stable(port_line_oe_o))
    else $error("oe moved");
  rd_keep_a: assert property (!io_rd_i |=> $stable(io_rdata_o))
    else $error("read data moved");
  wr_clear_a: assert property (ch_wr |=> !adc_irq_o)
    else $error("done kept");
  rd_clear_a: assert property (res_rd && !conv_done_i |=> !adc_irq_o)
    else $error("done kept");
  irq_gate_a: assert property (!irq_enable_i |-> !adc_irq_o)
    else $error("irq not gated");
  done_set_a: assert property (busy_r && conv_done_i && !ch_wr && irq_enable_i |=>
    adc_irq_o) else $error("done not set");
  hi_blank_a: assert property (io_rd_i && io_addr_i == 16'h01D9 |=>
    io_rdata_o[7:4] == 4'h0) else $error("high bits set");
endmodule
bind adc_status_and_dio_direction adc_status_and_dio_direction_chk chk_u (
  .clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i), .io_rd_i(io_rd_i),
  .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o),
  .conv_start_o(conv_start_o), .channel_select_o(channel_select_o),
  .conv_done_i(conv_done_i), .irq_enable_i(irq_enable_i), .adc_irq_o(adc_irq_o),
  .port_line_oe_o(port_line_oe_o));

// ---- adc_status_and_dio_direction_test.sv ----
// self-checking bench for the converter status and port direction block
`timescale 1ns/10ps
module adc_status_and_dio_direction_test;
  localparam logic [15:0] A3 = 16'h01D3, A4 = 16'h01D4, A5 = 16'h01D5, A8 = 16'h01D8;
  localparam logic [15:0] A9 = 16'h01D9;
  logic clock_i = 1'b0, nrst_i = 1'b0, io_rd_i = 1'b0, io_wr_i = 1'b0, io_word_i = 1'b0;
  logic irq_enable_i = 1'b0, slow = 1'b0, conv_start_o, conv_done_i, adc_irq_o;
  logic [15:0] io_addr_i = 16'h0000, port_line_i = 16'hA55A;
  logic [15:0] io_rdata_o, port_line_o, port_line_oe_o, got;
  logic [11:0] code = 12'h000, conv_result_i;
  logic [7:0] io_wdata_i = 8'h00;
  logic [2:0] channel_select_o;
  int n_mismatch = 0, checks_done = 0;
  // channel byte, result code, word read at the low address
  logic [35:0] rows [8] = '{{8'hF8, 12'h000, 16'h0000}, {8'h01, 12'h001, 16'h0001},
    {8'h0A, 12'h400, 16'h0400}, {8'h03, 12'h800, 16'h0800}, {8'hFC, 12'hFFF, 16'h0FFF},
    {8'h05, 12'hA5C, 16'h0A5C}, {8'h06, 12'h123, 16'h0123}, {8'h87, 12'h7FE, 16'h07FE}};
  always #20 clock_i = ~clock_i;
  adc_status_and_dio_direction dut_u (.clock_i(clock_i), .nrst_i(nrst_i),
    .io_addr_i(io_addr_i), .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_word_i(io_word_i),
    .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .conv_start_o(conv_start_o),
    .channel_select_o(channel_select_o), .conv_done_i(conv_done_i),
    .conv_result_i(conv_result_i), .irq_enable_i(irq_enable_i), .adc_irq_o(adc_irq_o),
    .port_line_i(port_line_i), .port_line_o(port_line_o), .port_line_oe_o(port_line_oe_o));
  conv_model conv_u (.clock_i(clock_i), .nrst_i(nrst_i), .start_i(conv_start_o),
    .slow_i(slow), .code_i(code), .done_o(conv_done_i), .result_o(conv_result_i));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clock_i);
    {io_addr_i, io_wdata_i, io_wr_i} = {a, d, 1'b1};
    @(negedge clock_i);
    io_wr_i = 1'b0;
  endtask
  // an expected value of all ones means read only
  task automatic rc(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(negedge clock_i);
    {io_addr_i, io_word_i, io_rd_i} = {a, w, 1'b1};
    @(negedge clock_i);
    io_rd_i = 1'b0;
    got = io_rdata_o;
    if (e !== 16'hFFFF) cmp(got, e);
  endtask
  task automatic wait_done();
    got = 16'h0000;
    for (int i = 0; i < 40 && got[7] !== 1'b1; i++) rc(A3, 1'b0, 16'hFFFF);
    cmp({8'h00, got[7], 7'h00}, 16'h0080);
    if (got[7] !== 1'b1) close_out();
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    nrst_i = 1'b1;
    rc(A3, 1'b0, 16'h0000);
    for (int k = 0; k < 8; k++) begin
      {code, irq_enable_i, slow} = {rows[k][27:16], k[0], k[1]};
      wr(A8, rows[k][35:28]);
      cmp({13'h0000, channel_select_o}, {13'h0000, rows[k][30:28]});
      rc(A3, 1'b0, 16'h0000);
      wait_done();
      cmp({15'h0000, adc_irq_o}, {15'h0000, k[0]});
      rc(A8, 1'b1, rows[k][15:0]);
      rc(A3, 1'b0, 16'h0000);
    end
    wr(A9, 8'hFF);
    rc(A8, 1'b0, 16'h00FE);
    rc(A9, 1'b0, 16'h0007);
    wr(A3, 8'hFD);
    cmp(port_line_oe_o, 16'h00FF);
    wr(A4, 8'h3C);
    cmp(port_line_o & 16'h00FF, 16'h003C);
    rc(A4, 1'b0, 16'h003C);
    rc(A5, 1'b0, 16'h00A5);
    wr(A3, 8'h02);
    cmp(port_line_oe_o, 16'hFF00);
    rc(A4, 1'b0, 16'h005A);
    wr(A5, 8'hC3);
    cmp(port_line_o, 16'hC33C);
    rc(A5, 1'b0, 16'h00C3);
    // a channel write clears done, and a second one restarts the conversion
    {code, slow, irq_enable_i} = {12'h321, 1'b1, 1'b1};
    wr(A8, 8'h01);
    wait_done();
    code = 12'h654;
    wr(A8, 8'h06);
    rc(A3, 1'b0, 16'h0002);
    wr(A8, 8'h05);
    cmp({13'h0000, channel_select_o}, 16'h0005);
    rc(A3, 1'b0, 16'h0002);
    wait_done();
    rc(A9, 1'b0, 16'h0006);
    rc(A3, 1'b0, 16'h0002);
    rc(A8, 1'b1, 16'h0654);
    // reset in mid-run: ports back to input, port data and result cleared
    nrst_i = 1'b0;
    @(negedge clock_i);
    cmp(port_line_oe_o, 16'h0000);
    cmp(port_line_o, 16'h0000);
    repeat (7) @(negedge clock_i);
    nrst_i = 1'b1;
    rc(A3, 1'b0, 16'h0000);
    rc(A8, 1'b1, 16'h0000);
    close_out();
  end
endmodule
